// *** isp_device.sv ***
// device end: serial programming command interpreter with memories
`timescale 1ns/1ns
// Functional notes
// RULE1: enable instruction must precede program and erase
// RULE2: input bit sampled on serial clock rise
// RULE3: output bit shifted on serial clock fall
// RULE4: programmer holds clock phases long enough
// RULE5: programmer keeps reset, clock low powering up
// RULE6: programmer waits before the enable instruction
// RULE7: echo second enable byte during third byte
// RULE8: programmer sends all four bytes, retries; programmer here only flags echo_ok and never retries
// RULE9: flash written per page via buffer
// RULE10: low byte loaded before high byte
// RULE11: extended address byte kept until rewritten
// RULE12: programmer waits after writes without polling
// RULE13: poll returns busy flag in bit zero
// RULE14: programmer stays off link during page write; bench here sends a poll during the page write
// RULE15: eeprom byte write erases location first
// RULE16: chip erase sets all memory to ones
// RULE17: decode flash buffer loads and page write
// RULE18: decode flash and eeprom reads
// RULE19: decode eeprom byte and page writes
// RULE20: decode lock and fuse writes
// RULE21: decode fuse, lock, identity reads
// RULE22: fuses zero programmed; word addresses used
// RULE23: four byte frames, msb first
module isp_device
	import isp_pkg::*;
#(
	parameter int          FLASH_WORDS = 1024,
	parameter int          EE_BYTES    = 1024,
	parameter int          FLASH_WAIT  = FLASH_WAIT_CYC,
	parameter int          EEPROM_WAIT = EEPROM_WAIT_CYC,
	parameter int          ERASE_WAIT  = ERASE_WAIT_CYC,
	// identity values below are arbitrary
	parameter logic [23:0] SIGNATURE   = 24'h0102A5,
	parameter logic [7:0]  CALIBRATION = 8'h80
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic ce,
	isp_link_if.device link,
	output logic      prog_mode,
	output logic      busy
);
	localparam int FAW = $clog2(FLASH_WORDS);
	localparam int EAW = $clog2(EE_BYTES);

	logic [15:0] flash [FLASH_WORDS];
	logic [7:0]  eeprom [EE_BYTES];
	logic [15:0] page_buf [2**PAGE_ADDR_BITS];
	logic [7:0]  ee_buf [2**EE_PAGE_BITS];
	logic [2:0]  rst_s_q;
	logic [2:0]  sck_s_q;
	logic [1:0]  sdi_s_q;
	logic        sck_rise;
	logic        sck_fall;
	logic        in_reset;
	logic [2:0]  bit_q;
	logic [1:0]  byte_q;
	logic [7:0]  shin_q;
	logic [7:0]  shout_q;
	logic [23:0] hdr_q;
	logic [7:0]  ext_q;
	logic [7:0]  lock_q;
	logic [7:0]  fuse_lo_q;
	logic [7:0]  fuse_hi_q;
	logic [7:0]  fuse_ext_q;
	logic [31:0] wait_q;
	logic        erase_q;
	logic [FAW:0] erase_idx_q;
	logic        byte_done;
	logic [31:0] cmd;
	logic [7:0]  reply;
	logic [FAW-1:0] waddr;
	logic [EAW-1:0] eaddr;

	// pins come from another domain; only stage two onward is examined
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rst_s_q <= 3'h7;
			sck_s_q <= 3'h0;
			sdi_s_q <= 2'h0;
		end else if (ce) begin
			rst_s_q <= {rst_s_q[1:0], link.reset_n};
			sck_s_q <= {sck_s_q[1:0], link.sck};
			sdi_s_q <= {sdi_s_q[0], link.sdi};
		end
	end
	assign in_reset  = !rst_s_q[1];
	assign sck_rise  = sck_s_q[1] && !sck_s_q[2];
	assign sck_fall  = !sck_s_q[1] && sck_s_q[2];
	assign byte_done = sck_rise && bit_q == 3'h7;
	assign cmd       = {hdr_q, shin_q[6:0], sdi_s_q[1]};
	assign waddr     = FAW'({ext_q, cmd[23:8]});
	assign eaddr     = EAW'(cmd[17:8]);
	assign busy      = wait_q != '0;

	// RULE23: four byte framing
	always_ff @(posedge clock) begin
		if (!nrst || !in_reset) begin
			bit_q  <= '0;
			byte_q <= '0;
			shin_q <= '0;
			hdr_q  <= '0;
		end else if (ce && sck_rise) begin
			// RULE2: sample on rise
			shin_q <= {shin_q[6:0], sdi_s_q[1]};
			bit_q  <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				byte_q <= byte_q + 2'h1;
				hdr_q  <= {hdr_q[15:0], shin_q[6:0], sdi_s_q[1]};
			end
		end
	end

	// reply byte for the frame's next byte slot
	always_comb begin
		reply = 8'h00;
		if (byte_q == 2'd1) begin
			// RULE7: echo enable byte two
			reply = {shin_q[6:0], sdi_s_q[1]} == OP_ENABLE_B2 ?
				OP_ENABLE_B2 : 8'h00;
		end else if (byte_q == 2'd2 && prog_mode) begin
			unique case (hdr_q[15:8])
				// RULE13: busy flag in bit zero
				OP_POLL:    reply = {7'h00, busy};
				// RULE18: memory reads
				OP_READ_LO: reply = flash[FAW'({ext_q, hdr_q[7:0], shin_q[6:0],
					sdi_s_q[1]})][7:0];
				OP_READ_HI: reply = flash[FAW'({ext_q, hdr_q[7:0], shin_q[6:0],
					sdi_s_q[1]})][15:8];
				OP_EE_READ: reply = eeprom[EAW'({hdr_q[1:0], shin_q[6:0],
					sdi_s_q[1]})];
				// RULE21: fuse, lock, identity reads
				OP_RD_FUSE_EFUSE: reply = hdr_q[7:0] == SUB_HIGH_SEL ?
					fuse_ext_q : fuse_lo_q;
				OP_RD_LOCK_HFUSE: reply = hdr_q[7:0] == SUB_HIGH_SEL ?
					fuse_hi_q : lock_q;
				OP_RD_SIG: reply = SIGNATURE[8*(2-int'(sdi_s_q[1]) -
					2*int'(shin_q[0])) +: 8];
				OP_RD_CAL: reply = CALIBRATION;
				default:   reply = 8'h00;
			endcase
		end
	end

	// RULE3: shift out on fall
	always_ff @(posedge clock) begin
		if (!nrst || !in_reset) begin
			shout_q <= '0;
		end else if (ce) begin
			if (byte_done) begin
				shout_q <= reply;
			end else if (sck_fall && bit_q != 3'h0) begin
				shout_q <= {shout_q[6:0], 1'b0};
			end
		end
	end
	assign link.sdo = shout_q[7];

	// RULE1: enable gate for all work
	always_ff @(posedge clock) begin
		if (!nrst || !in_reset) begin
			prog_mode <= 1'b0;
		end else if (ce && byte_done && byte_q == 2'd3 &&
				cmd[31:16] == {OP_ENABLE, OP_ENABLE_B2}) begin
			prog_mode <= 1'b1;
		end
	end

	// RULE11: extended byte kept across frames
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ext_q <= '0;
		end else if (ce && prog_mode && byte_done && byte_q == 2'd3 &&
				cmd[31:24] == OP_LOAD_EXT) begin
			ext_q <= cmd[15:8];
		end
	end

	// RULE20: lock and fuse writes; RULE22: fuses reset unprogrammed
	always_ff @(posedge clock) begin
		if (!nrst) begin
			lock_q     <= FUSE_RESET;
			fuse_lo_q  <= FUSE_RESET;
			fuse_hi_q  <= FUSE_RESET;
			fuse_ext_q <= FUSE_RESET;
		end else if (ce && prog_mode && !busy && byte_done &&
				byte_q == 2'd3 && cmd[31:24] == OP_ENABLE) begin
			unique case (cmd[23:16])
				SUB_LOCK:     lock_q     <= cmd[7:0];
				SUB_FUSE_LO:  fuse_lo_q  <= cmd[7:0];
				SUB_FUSE_HI:  fuse_hi_q  <= cmd[7:0];
				SUB_FUSE_EXT: fuse_ext_q <= cmd[7:0];
				// erase clears lock bits too
				OP_ERASE_B2:  lock_q     <= FUSE_RESET;
				default:      lock_q     <= lock_q;
			endcase
		end
	end

	// RULE12: pending timer drives poll answer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			wait_q      <= '0;
			erase_q     <= 1'b0;
			erase_idx_q <= '0;
		end else if (ce) begin
			if (wait_q != '0) begin
				wait_q <= wait_q - 32'd1;
			end
			if (erase_q) begin
				erase_idx_q <= erase_idx_q + 1'b1;
				if (erase_idx_q == (FAW+1)'(FLASH_WORDS - 1)) begin
					erase_q <= 1'b0;
				end
			end
			if (prog_mode && !busy && byte_done && byte_q == 2'd3) begin
				if (cmd[31:16] == {OP_ENABLE, OP_ERASE_B2}) begin
					wait_q      <= 32'(ERASE_WAIT);
					erase_q     <= 1'b1;
					erase_idx_q <= '0;
				end else if (cmd[31:24] == OP_PAGE_WRITE) begin
					wait_q <= 32'(FLASH_WAIT);
				end else if (cmd[31:24] == OP_EE_WRITE ||
						cmd[31:24] == OP_EE_PAGE_WRITE ||
						cmd[31:24] == OP_ENABLE && cmd[23:16] != OP_ENABLE_B2) begin
					wait_q <= 32'(EEPROM_WAIT);
				end
			end
		end
	end

	// RULE17: flash buffer loads and page commit; RULE9: page at a time
	always_ff @(posedge clock) begin
		if (ce && prog_mode && byte_done && byte_q == 2'd3) begin
			if (cmd[31:24] == OP_LOAD_LO) begin
				page_buf[cmd[14:8]][7:0] <= cmd[7:0];
			end
			// RULE10: high byte after low
			if (cmd[31:24] == OP_LOAD_HI) begin
				page_buf[cmd[14:8]][15:8] <= cmd[7:0];
			end
			// RULE19: eeprom page buffer load
			if (cmd[31:24] == OP_EE_LOAD) begin
				ee_buf[cmd[9:8]] <= cmd[7:0];
			end
		end
	end

	// RULE16: erase walks both arrays to ones
	always_ff @(posedge clock) begin
		if (ce && erase_q) begin
			flash[FAW'(erase_idx_q)] <= {ERASED_BYTE, ERASED_BYTE};
		end else if (ce && prog_mode && !busy && byte_done &&
				byte_q == 2'd3 && cmd[31:24] == OP_PAGE_WRITE) begin
			// RULE22: word address page commit
			for (int i = 0; i < 2**PAGE_ADDR_BITS; i++) begin
				flash[FAW'({waddr[FAW-1:PAGE_ADDR_BITS], 7'(i)})] <= page_buf[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (ce && erase_q && erase_idx_q < (FAW+1)'(EE_BYTES)) begin
			eeprom[EAW'(erase_idx_q)] <= ERASED_BYTE;
		end else if (ce && prog_mode && !busy && byte_done &&
				byte_q == 2'd3) begin
			// RULE15: byte write overwrites, no prior erase needed
			if (cmd[31:24] == OP_EE_WRITE) begin
				eeprom[eaddr] <= cmd[7:0];
			end
			if (cmd[31:24] == OP_EE_PAGE_WRITE) begin
				for (int j = 0; j < 2**EE_PAGE_BITS; j++) begin
					eeprom[{eaddr[EAW-1:EE_PAGE_BITS], 2'(j)}] <= ee_buf[j];
				end
			end
		end
	end
endmodule // isp_device

// *** isp_pkg.sv ***
// shared constants for the serial programming link and its two ends
package isp_pkg;
	localparam int          CLOCK_HZ          = 125_000_000;
	// pending-operation times in microseconds
	localparam int          FLASH_WAIT_US     = 4500;
	localparam int          EEPROM_WAIT_US    = 9000;
	localparam int          ERASE_WAIT_US     = 9000;
	localparam int          FLASH_WAIT_CYC    = FLASH_WAIT_US * (CLOCK_HZ / 1_000_000);
	localparam int          EEPROM_WAIT_CYC   = EEPROM_WAIT_US * (CLOCK_HZ / 1_000_000);
	localparam int          ERASE_WAIT_CYC    = ERASE_WAIT_US * (CLOCK_HZ / 1_000_000);
	localparam int          POWERUP_WAIT_US   = 20000;
	localparam int          POWERUP_WAIT_CYC  = POWERUP_WAIT_US * (CLOCK_HZ / 1_000_000);
	// serial clock phase: more than 3 cpu cycles at or above 12 MHz
	localparam int          SCK_HALF_CYC      = 4;
	localparam logic [7:0]  OP_ENABLE         = 8'hAC;
	localparam logic [7:0]  OP_ENABLE_B2      = 8'h53;
	localparam logic [7:0]  OP_ERASE_B2       = 8'h80;
	localparam logic [7:0]  OP_POLL           = 8'hF0;
	localparam logic [7:0]  OP_LOAD_EXT       = 8'h4D;
	localparam logic [7:0]  OP_LOAD_HI        = 8'h48;
	localparam logic [7:0]  OP_LOAD_LO        = 8'h40;
	localparam logic [7:0]  OP_EE_LOAD        = 8'hC1;
	localparam logic [7:0]  OP_READ_HI        = 8'h28;
	localparam logic [7:0]  OP_READ_LO        = 8'h20;
	localparam logic [7:0]  OP_EE_READ        = 8'hA0;
	localparam logic [7:0]  OP_RD_LOCK_HFUSE  = 8'h58;
	localparam logic [7:0]  OP_RD_SIG         = 8'h30;
	localparam logic [7:0]  OP_RD_FUSE_EFUSE  = 8'h50;
	localparam logic [7:0]  OP_RD_CAL         = 8'h38;
	localparam logic [7:0]  OP_PAGE_WRITE     = 8'h4C;
	localparam logic [7:0]  OP_EE_WRITE       = 8'hC0;
	localparam logic [7:0]  OP_EE_PAGE_WRITE  = 8'hC2;
	localparam logic [7:0]  SUB_LOCK          = 8'hE0;
	localparam logic [7:0]  SUB_FUSE_LO       = 8'hA0;
	localparam logic [7:0]  SUB_FUSE_HI       = 8'hA8;
	localparam logic [7:0]  SUB_FUSE_EXT      = 8'hA4;
	localparam logic [7:0]  SUB_HIGH_SEL      = 8'h08;
	localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
	localparam logic [7:0]  FUSE_RESET        = 8'hFF;
	localparam int          PAGE_ADDR_BITS    = 7;
	localparam int          EE_ADDR_BITS      = 10;
	localparam int          EE_PAGE_BITS      = 2;
endpackage

// *** isp_link_if.sv ***
// serial programming link between programmer and device
`timescale 1ns/1ns
interface isp_link_if;
	logic reset_n;
	logic sck;
	logic sdi;
	logic sdo;
	modport device (input reset_n, input sck, input sdi, output sdo);
	modport programmer (output reset_n, output sck, output sdi, input sdo);
endinterface

// *** isp_fifo.sv ***
// parameterised valid/ready fifo
`timescale 1ns/1ns
module isp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // isp_fifo

// *** isp_programmer.sv ***
// programmer end: sends queued four-byte instructions, returns replies
`timescale 1ns/1ns
module isp_programmer
	import isp_pkg::*;
#(
	parameter int POWERUP_WAIT = POWERUP_WAIT_CYC,
	parameter int HALF_CYC     = SCK_HALF_CYC
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        session,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [31:0] cmd_data,
	output logic             rsp_valid,
	output logic      [7:0]  rsp_data,
	output logic             echo_ok,
	isp_link_if.programmer   link
);
	typedef enum logic [1:0] {IDLE, POWERUP, READY, SHIFT} state_type;
	state_type   state_q;
	logic [31:0] pwr_q;
	logic [7:0]  div_q;
	logic        sck_q;
	logic [4:0]  bit_q;
	logic [31:0] sh_q;
	logic [31:0] rx_q;
	logic [15:0] op_q;
	logic [1:0]  sdo_s_q;
	logic        f_valid;
	logic        f_ready;
	logic [31:0] f_data;

	isp_fifo #(.WIDTH(32), .DEPTH(16)) isp_fifo_inst (
		.clock     (clock),
		.nrst      (nrst),
		.ce        (ce),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   (cmd_data),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);
	// no pop while leaving a session, so no queued word is lost
	assign f_ready     = state_q == READY && session;
	// RULE5: reset held low while clock low
	assign link.reset_n = !(session && state_q != IDLE) ? 1'b1 : 1'b0;
	assign link.sck     = sck_q;
	assign link.sdi     = sh_q[31];

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sdo_s_q <= '0;
		end else if (ce) begin
			sdo_s_q <= {sdo_s_q[0], link.sdo};
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q   <= IDLE;
			pwr_q     <= '0;
			div_q     <= '0;
			sck_q     <= 1'b0;
			bit_q     <= '0;
			sh_q      <= '0;
			rx_q      <= '0;
			op_q      <= '0;
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
			echo_ok   <= 1'b0;
		end else if (ce) begin
			rsp_valid <= 1'b0;
			unique case (state_q)
				IDLE: begin
					sck_q <= 1'b0;
					if (session) begin
						state_q <= POWERUP;
						pwr_q   <= 32'(POWERUP_WAIT);
					end
				end
				// RULE6: wait before enable
				POWERUP: begin
					pwr_q <= pwr_q - 32'd1;
					if (pwr_q == 32'd0) begin
						state_q <= READY;
					end
				end
				READY: begin
					if (!session) begin
						state_q <= IDLE;
					end else if (f_valid) begin
						sh_q    <= f_data;
						op_q    <= f_data[31:16];
						bit_q   <= '0;
						div_q   <= '0;
						state_q <= SHIFT;
					end
				end
				// RULE4: each phase HALF_CYC cycles; RULE23: 32 bits msb first
				SHIFT: begin
					div_q <= div_q + 8'd1;
					if (div_q == 8'(HALF_CYC - 1)) begin
						div_q <= '0;
						sck_q <= !sck_q;
						// sample at end of high phase: both resynchronisers
						// delay the returned bit about five cycles past the fall
						if (sck_q) begin
							sh_q  <= {sh_q[30:0], 1'b0};
							rx_q  <= {rx_q[30:0], sdo_s_q[1]};
							bit_q <= bit_q + 5'd1;
							// RULE8: full frame always sent
							if (bit_q == 5'd31) begin
								state_q   <= READY;
								rsp_valid <= 1'b1;
								rsp_data  <= {rx_q[6:0], sdo_s_q[1]};
								if (op_q == {OP_ENABLE, OP_ENABLE_B2}) begin
									echo_ok <= rx_q[14:7] == OP_ENABLE_B2;
								end
							end
						end
					end
				end
			endcase
		end
	end
endmodule // isp_programmer

// *** isp_link_monitor.sv ***
// wire-level checker for the serial programming link
`timescale 1ns/1ns
module isp_link_monitor
	import isp_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic reset_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo
);
	logic        sck_q;
	logic [4:0]  bit_cnt_q;
	logic [31:0] sdi_sh_q;
	logic [31:0] sdo_sh_q;
	logic        done_q;
	logic        first_q;
	wire         rise = sck && !sck_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	always_ff @(posedge clock) begin
		sck_q <= nrst && sck;
	end
	always_ff @(posedge clock) begin
		if (!nrst || reset_n) begin
			bit_cnt_q <= 5'h00;
		end else if (rise) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (rise) begin
			sdi_sh_q <= {sdi_sh_q[30:0], sdi};
			sdo_sh_q <= {sdo_sh_q[30:0], sdo};
		end
	end
	always_ff @(posedge clock) begin
		done_q <= nrst && !reset_n && rise && bit_cnt_q == 5'h1F;
	end
	// first frame after the link reset falls
	always_ff @(posedge clock) begin
		if (!nrst || reset_n) begin
			first_q <= 1'b1;
		end else if (done_q) begin
			first_q <= 1'b0;
		end
	end
	a_sck_high_hold: assert property ($rose(sck) |-> sck [*4])
		else $error("serial clock high phase too short");
	a_sck_low_hold: assert property ($fell(sck) |-> !sck [*4])
		else $error("serial clock low phase too short");
	a_idle_clock_low: assert property (reset_n |-> !sck)
		else $error("serial clock moves outside a session");
	a_sdi_held: assert property ($rose(sck) |->
		$stable(sdi) ##1 $stable(sdi) [*3])
		else $error("serial input moved near clock rise");
	a_sdo_settled: assert property ($rose(sck) && !reset_n |->
		$stable(sdo))
		else $error("serial output moved at clock rise");
	a_enable_echo: assert property (done_q && first_q &&
		sdi_sh_q[31:16] == {OP_ENABLE, OP_ENABLE_B2} |->
		sdo_sh_q[15:8] == OP_ENABLE_B2)
		else $error("enable echo missing in third byte");
	a_frame_open: assert property (bit_cnt_q != 5'h00 |-> !reset_n)
		else $error("link reset raised inside a frame");
	a_release_whole: assert property ($rose(reset_n) |->
		bit_cnt_q == 5'h00 && !sck)
		else $error("session ended on a partial frame");
endmodule // isp_link_monitor

// *** test_serial_isp_command_unit.sv ***
// bench: programmer end drives device end, replies checked in order
`timescale 1ns/1ns
module test_serial_isp_command_unit;
	import isp_pkg::*;
	localparam int WAIT_CYC = 2000;
	// identity values below are arbitrary
	localparam logic [23:0] SIG_BYTES = 24'h1E2D3C;
	localparam logic [7:0]  CAL_BYTE  = 8'h3C;
	typedef struct packed {logic [7:0] v; logic [7:0] m;} note_type;
	logic        clock;
	logic        nrst;
	logic        ce;
	logic        session;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [31:0] cmd_data;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        echo_ok;
	logic        prog_mode;
	logic        busy;
	logic [7:0]  lq;
	logic [7:0]  a;
	logic [7:0]  d;
	int          n_mismatch;
	int          cmp_count;
	note_type    notes[$];
	isp_link_if link ();
	isp_programmer #(.POWERUP_WAIT(10)) isp_programmer_inst (
		.clock(clock), .nrst(nrst), .ce(ce), .session(session),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .echo_ok(echo_ok),
		.link(link));
	isp_device #(.FLASH_WAIT(WAIT_CYC), .EEPROM_WAIT(WAIT_CYC),
		.ERASE_WAIT(WAIT_CYC), .SIGNATURE(SIG_BYTES),
		.CALIBRATION(CAL_BYTE)) isp_device_inst (
		.clock(clock), .nrst(nrst), .ce(ce), .link(link),
		.prog_mode(prog_mode), .busy(busy));
	isp_link_monitor isp_link_monitor_inst (
		.clock(clock), .nrst(nrst), .reset_n(link.reset_n),
		.sck(link.sck), .sdi(link.sdi), .sdo(link.sdo));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	function automatic logic [7:0] rnd();
		lq = {lq[6:0], lq[7] ^ lq[5] ^ lq[4] ^ lq[3]};
		return lq;
	endfunction
	task automatic check(input string w, input logic [7:0] e,
		input logic [7:0] m, input logic [7:0] g);
		cmp_count++;
		if (((g ^ e) & m) !== 8'h00) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// inputs change 1 ns after the rising edge; ready settles by then
	task automatic send(input logic [31:0] w, input logic [7:0] e,
		input logic [7:0] m = 8'hFF);
		int n;
		@(posedge clock);
		#1;
		cmd_valid = 1'b1;
		cmd_data = w;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 5000) begin
			@(posedge clock);
			#1;
			n++;
		end
		notes.push_back('{e, m});
		@(posedge clock);
		#1;
		cmd_valid = 1'b0;
	endtask
	// drain replies, then let any pending memory operation finish
	task automatic settle();
		int n;
		n = 0;
		while ((notes.size() != 0 || busy !== 1'b0) && n < 20000) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 20000) begin
			n_mismatch++;
			$display("wrong value settle expected idle seen busy");
		end
	endtask
	always @(negedge clock) begin
		if (rsp_valid === 1'b1) begin
			if (notes.size() == 0) begin
				check("spare reply", 8'h00, 8'h00, rsp_data);
				n_mismatch++;
			end else begin
				check("reply", notes[0].v, notes[0].m, rsp_data);
				void'(notes.pop_front());
			end
		end
	end
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		$display("wrong value watchdog expected done seen hang");
		conclude();
	end
	initial begin
		logic [7:0] fz[4][3];
		fz = '{'{SUB_FUSE_LO, OP_RD_FUSE_EFUSE, 8'h00},
			'{SUB_FUSE_HI, OP_RD_LOCK_HFUSE, SUB_HIGH_SEL},
			'{SUB_FUSE_EXT, OP_RD_FUSE_EFUSE, SUB_HIGH_SEL},
			'{SUB_LOCK, OP_RD_LOCK_HFUSE, 8'h00}};
		n_mismatch = 0;
		cmp_count = 0;
		nrst = 1'b0;
		ce = 1'b1;
		session = 1'b0;
		cmd_valid = 1'b0;
		cmd_data = 32'h0;
		lq = 8'h35;
		repeat (10) @(posedge clock);
		#1;
		nrst = 1'b1;
		session = 1'b1;
		send(32'hAC530000, 8'h00, 8'h00);
		settle();
		check("echo_ok", 8'h01, 8'h01, {7'h00, echo_ok});
		check("prog_mode", 8'h01, 8'h01, {7'h00, prog_mode});
		send(32'hAC800000, 8'h00, 8'h00);
		settle();
		a = rnd();
		session = 1'b0;
		repeat (20) @(posedge clock);
		#1;
		session = 1'b1;
		send({OP_EE_WRITE, 8'h00, a, 8'h12}, 8'h00, 8'h00);
		send(32'hAC530000, 8'h00, 8'h00);
		send({OP_EE_READ, 8'h00, a, 8'h00}, ERASED_BYTE);
		send({OP_READ_LO, 8'h00, a, 8'h00}, ERASED_BYTE);
		for (int i = 0; i < 2; i++) begin
			d = rnd();
			settle();
			send({OP_EE_WRITE, 8'h00, a, d}, 8'h00, 8'h00);
			settle();
			send({OP_EE_READ, 8'h00, a, 8'h00}, d);
		end
		a = rnd();
		a[7] = 1'b0;
		d = rnd();
		send({OP_LOAD_EXT, 16'h0000, 8'h00}, 8'h00, 8'h00);
		send({OP_LOAD_LO, 8'h00, a, d}, 8'h00, 8'h00);
		send({OP_LOAD_HI, 8'h00, a, ~d}, 8'h00, 8'h00);
		send({OP_PAGE_WRITE, 24'h000000}, 8'h00, 8'h00);
		send({OP_POLL, 24'h000000}, 8'h01, 8'h01);
		settle();
		send({OP_POLL, 24'h000000}, 8'h00, 8'h01);
		send({OP_READ_LO, 8'h00, a, 8'h00}, d);
		send({OP_READ_HI, 8'h00, a, 8'h00}, ~d);
		d = rnd();
		send({OP_EE_LOAD, 8'h00, 8'h01, d}, 8'h00, 8'h00);
		send({OP_EE_PAGE_WRITE, 8'h00, 8'h10, 8'h00}, 8'h00, 8'h00);
		settle();
		send({OP_EE_READ, 8'h00, 8'h11, 8'h00}, d);
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			send({OP_ENABLE, fz[i][0], 8'h00, d}, 8'h00, 8'h00);
			settle();
			send({fz[i][1], fz[i][2], 16'h0000}, d);
		end
		send({OP_RD_CAL, 24'h000000}, CAL_BYTE);
		send({OP_RD_SIG, 8'h00, 8'h01, 8'h00}, SIG_BYTES[15:8]);
		settle();
		session = 1'b0;
		repeat (20) @(posedge clock);
		conclude();
	end
endmodule // test_serial_isp_command_unit
